// ---- hw/snvbl_top.sv ----
// serial byte loader for the 256-byte non-volatile array
`timescale 1ns/100ps
module snvbl_top #(
    parameter int unsigned STEP_CYC = snvbl_pkg::STEP_CYC,
    parameter int unsigned BIT_CYC  = snvbl_pkg::BIT_CYC
) (
    // clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_srst,
    // serial pins
    input  wire logic       i_rxd,
    output logic            o_txd,
    // security and self-test
    input  wire logic       i_security_bit,
    input  wire logic       i_selftest,
    // array status
    output logic            o_busy,
    output logic            o_erasing,
    output logic            o_programming,
    output logic            o_locked,
    output logic [7:0]      o_last_addr
);
    localparam logic [23:0] STEP_C = 24'(STEP_CYC - 1);

    // the array itself: 256 bytes, reset leaves contents as they were
    logic [7:0] mem_arr [snvbl_pkg::ARRAY_DEPTH];

    snvbl_pkg::snvbl_state_t st_reg, st_next;
    logic [23:0] tmr_reg, tmr_next;
    logic [7:0]  addr_hi_reg, addr_hi_next;
    logic [7:0]  addr_reg, addr_next;
    logic [7:0]  data_reg, data_next;
    logic [7:0]  echo_reg, echo_next;
    logic        tx_go_reg, tx_go_next;
    logic        txd_reg, busy_reg, era_reg, prg_reg, lock_reg;
    logic        wr_en;
    logic [7:0]  wr_val;
    logic        wipe_en;
    logic [7:0]  wipe_idx_reg, wipe_idx_next;
    logic [7:0]  rx_data;
    logic        rx_valid, tx_busy, txd_w;

    ////////////////////////////////////////////////////////////////////////
    // serial port
    snvbl_uart #(.BIT_CYC(BIT_CYC)) u_port (
        .i_clk_sys  (i_clk_sys),
        .i_srst     (i_srst),
        .i_rxd      (i_rxd),
        .o_txd      (txd_w),
        .o_rx_data  (rx_data),
        .o_rx_valid (rx_valid),
        .i_tx_data  (echo_reg),
        .i_tx_start (tx_go_reg),
        .o_tx_busy  (tx_busy)
    );

    ////////////////////////////////////////////////////////////////////////
    // sequencer next state
    always_comb begin
        st_next       = st_reg;
        tmr_next      = tmr_reg;
        addr_hi_next  = addr_hi_reg;
        addr_next     = addr_reg;
        data_next     = data_reg;
        echo_next     = echo_reg;
        tx_go_next    = 1'b0;
        wr_en         = 1'b0;
        wr_val        = snvbl_pkg::ERASED_VALUE;
        wipe_en       = 1'b0;
        wipe_idx_next = wipe_idx_reg;
        case (st_reg)
            snvbl_pkg::SNVBL_IDLE: begin
                // security sampled after reset release, not at reset
                if (i_selftest) begin
                    st_next = snvbl_pkg::SNVBL_SELFTEST;
                    wipe_idx_next = 8'h00;
                end else if (i_security_bit) begin
                    st_next = snvbl_pkg::SNVBL_LOCKED;
                end else begin
                    st_next = snvbl_pkg::SNVBL_DISCARD;
                end
            end
            snvbl_pkg::SNVBL_DISCARD: begin
                // host sends a null while starting up; drop it
                if (rx_valid) begin
                    st_next = snvbl_pkg::SNVBL_ADDR_HI;
                end
            end
            snvbl_pkg::SNVBL_ECHO: begin
                if (!tx_busy) begin
                    echo_next  = mem_arr[addr_reg];
                    tx_go_next = 1'b1;
                    st_next    = snvbl_pkg::SNVBL_ADDR_HI;
                end
            end
            snvbl_pkg::SNVBL_ADDR_HI: begin
                if (rx_valid) begin
                    addr_hi_next = rx_data;
                    st_next      = snvbl_pkg::SNVBL_ADDR_LO;
                end
            end
            snvbl_pkg::SNVBL_ADDR_LO: begin
                if (rx_valid) begin
                    addr_next = rx_data;
                    st_next   = snvbl_pkg::SNVBL_DATA;
                end
            end
            snvbl_pkg::SNVBL_DATA: begin
                if (rx_valid) begin
                    data_next = rx_data;
                    tmr_next  = STEP_C;
                    st_next   = snvbl_pkg::SNVBL_ERASE;
                end
            end
            snvbl_pkg::SNVBL_ERASE: begin
                // bytes arriving now are ignored by design
                if (tmr_reg != 24'h000000) begin
                    tmr_next = tmr_reg - 24'h000001;
                end else begin
                    wr_en  = 1'b1;
                    wr_val = snvbl_pkg::ERASED_VALUE;
                    tmr_next = STEP_C;
                    if (data_reg == snvbl_pkg::ERASED_VALUE) begin
                        st_next = snvbl_pkg::SNVBL_READBACK;
                    end else begin
                        st_next = snvbl_pkg::SNVBL_PROGRAM;
                    end
                end
            end
            snvbl_pkg::SNVBL_PROGRAM: begin
                if (tmr_reg != 24'h000000) begin
                    tmr_next = tmr_reg - 24'h000001;
                end else begin
                    wr_en   = 1'b1;
                    wr_val  = data_reg;
                    st_next = snvbl_pkg::SNVBL_READBACK;
                end
            end
            snvbl_pkg::SNVBL_READBACK: begin
                st_next = snvbl_pkg::SNVBL_ECHO;
            end
            snvbl_pkg::SNVBL_SELFTEST: begin
                wipe_en       = 1'b1;
                wipe_idx_next = wipe_idx_reg + 8'h01;
                if (wipe_idx_reg == 8'hFF) begin
                    st_next = snvbl_pkg::SNVBL_DISCARD;
                end
            end
            snvbl_pkg::SNVBL_LOCKED: begin
                st_next = snvbl_pkg::SNVBL_LOCKED;
            end
            default: begin
                st_next = snvbl_pkg::SNVBL_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer and output registers
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            st_reg       <= snvbl_pkg::SNVBL_IDLE;
            tmr_reg      <= 24'h000000;
            addr_hi_reg  <= 8'h00;
            addr_reg     <= 8'h00;
            data_reg     <= 8'h00;
            echo_reg     <= snvbl_pkg::ECHO_RESET;
            tx_go_reg    <= 1'b0;
            wipe_idx_reg <= 8'h00;
            txd_reg      <= 1'b1;
            busy_reg     <= 1'b0;
            era_reg      <= 1'b0;
            prg_reg      <= 1'b0;
            lock_reg     <= 1'b0;
        end else begin
            st_reg       <= st_next;
            tmr_reg      <= tmr_next;
            addr_hi_reg  <= addr_hi_next;
            addr_reg     <= addr_next;
            data_reg     <= data_next;
            echo_reg     <= echo_next;
            tx_go_reg    <= tx_go_next;
            wipe_idx_reg <= wipe_idx_next;
            txd_reg      <= txd_w;
            busy_reg     <= (st_next == snvbl_pkg::SNVBL_ERASE) ||
                            (st_next == snvbl_pkg::SNVBL_PROGRAM) ||
                            (st_next == snvbl_pkg::SNVBL_SELFTEST);
            era_reg      <= (st_next == snvbl_pkg::SNVBL_ERASE);
            prg_reg      <= (st_next == snvbl_pkg::SNVBL_PROGRAM);
            lock_reg     <= (st_next == snvbl_pkg::SNVBL_LOCKED);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // array writes; high address byte is beyond a 256 byte array
    always_ff @(posedge i_clk_sys) begin
        if (wipe_en) begin
            mem_arr[wipe_idx_reg] <= snvbl_pkg::ERASED_VALUE;
        end else if (wr_en) begin
            mem_arr[addr_reg] <= wr_val;
        end
    end

    assign o_txd         = txd_reg;
    assign o_busy        = busy_reg;
    assign o_erasing     = era_reg;
    assign o_programming = prg_reg;
    assign o_locked      = lock_reg;
    assign o_last_addr   = addr_reg;

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_erase_len;
        @(posedge i_clk_sys) disable iff (i_srst)
        $rose(era_reg) |-> era_reg [*8];
    endproperty
    a_erase_len: assert property (p_erase_len)
        else $error("erase step ended too soon");

    property p_skip_prog;
        @(posedge i_clk_sys) disable iff (i_srst)
        (st_reg == snvbl_pkg::SNVBL_ERASE && tmr_reg == 24'h000000 &&
         data_reg == snvbl_pkg::ERASED_VALUE)
        |=> st_reg == snvbl_pkg::SNVBL_READBACK;
    endproperty
    a_skip_prog: assert property (p_skip_prog)
        else $error("program step not skipped for erased data");

    property p_prog_after_erase;
        @(posedge i_clk_sys) disable iff (i_srst)
        $rose(prg_reg) |-> $past(era_reg);
    endproperty
    a_prog_after_erase: assert property (p_prog_after_erase)
        else $error("program without erase");

    property p_lock;
        @(posedge i_clk_sys) disable iff (i_srst)
        (st_reg == snvbl_pkg::SNVBL_IDLE && i_security_bit && !i_selftest)
        |=> ##1 lock_reg;
    endproperty
    a_lock: assert property (p_lock)
        else $error("secured array not locked");

    property p_echo;
        @(posedge i_clk_sys) disable iff (i_srst)
        tx_go_reg |-> echo_reg == mem_arr[addr_reg];
    endproperty
    a_echo: assert property (p_echo)
        else $error("echo is not the stored byte");

    property p_no_accept;
        @(posedge i_clk_sys) disable iff (i_srst)
        // next cycle: the edge that starts the erase loads data on purpose
        (era_reg || prg_reg) |=> $stable(addr_reg) && $stable(data_reg);
    endproperty
    a_no_accept: assert property (p_no_accept)
        else $error("record bytes taken during a step");

    property p_readmode;
        @(posedge i_clk_sys) disable iff (i_srst)
        st_reg == snvbl_pkg::SNVBL_READBACK
        |=> st_reg == snvbl_pkg::SNVBL_ECHO ##1 !wr_en;
    endproperty
    a_readmode: assert property (p_readmode)
        else $error("array not back in read mode");

    property p_discard;
        @(posedge i_clk_sys) disable iff (i_srst)
        (st_reg == snvbl_pkg::SNVBL_DISCARD && rx_valid)
        |=> st_reg == snvbl_pkg::SNVBL_ADDR_HI && $stable(addr_hi_reg);
    endproperty
    a_discard: assert property (p_discard)
        else $error("first character not discarded");

    property p_wipe;
        @(posedge i_clk_sys) disable iff (i_srst)
        wipe_en |=> mem_arr[$past(wipe_idx_reg)] == snvbl_pkg::ERASED_VALUE;
    endproperty
    a_wipe: assert property (p_wipe)
        else $error("self-test did not erase byte");
endmodule : snvbl_top

// ---- hw/snvbl_pkg.sv ----
// constants shared by the serial byte loader files
package snvbl_pkg;
    localparam int unsigned CLK_HZ        = 125_000_000;
    localparam int unsigned BAUD_RATE     = 9600;
    localparam int unsigned BIT_CYC       = CLK_HZ / BAUD_RATE;
    localparam int unsigned HALF_BIT_CYC  = BIT_CYC / 2;
    localparam int unsigned STEP_MS       = 10;
    localparam int unsigned STEP_CYC      = (CLK_HZ / 1000) * STEP_MS;
    localparam int unsigned DATA_BITS     = 8;
    localparam int unsigned ARRAY_DEPTH   = 256;
    localparam int unsigned ADDR_W        = 8;
    localparam logic [7:0]  ERASED_VALUE  = 8'hFF;
    localparam logic [7:0]  ECHO_RESET    = 8'hFF;

    typedef enum logic [3:0] {
        SNVBL_IDLE     = 4'h0,
        SNVBL_DISCARD  = 4'h1,
        SNVBL_ECHO     = 4'h2,
        SNVBL_ADDR_HI  = 4'h3,
        SNVBL_ADDR_LO  = 4'h4,
        SNVBL_DATA     = 4'h5,
        SNVBL_ERASE    = 4'h6,
        SNVBL_PROGRAM  = 4'h7,
        SNVBL_READBACK = 4'h8,
        SNVBL_SELFTEST = 4'h9,
        SNVBL_LOCKED   = 4'hA
    } snvbl_state_t;
endpackage : snvbl_pkg

// ---- hw/snvbl_uart.sv ----
// async serial port: 8N1 receiver and transmitter at fixed baud
`timescale 1ns/100ps
module snvbl_uart #(
    parameter int unsigned BIT_CYC = snvbl_pkg::BIT_CYC
) (
    // clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_srst,
    // serial pins
    input  wire logic       i_rxd,
    output logic            o_txd,
    // received byte
    output logic [7:0]      o_rx_data,
    output logic            o_rx_valid,
    // byte to send
    input  wire logic [7:0] i_tx_data,
    input  wire logic       i_tx_start,
    output logic            o_tx_busy
);
    // 9600 baud by default; a shorter bit time keeps simulation short
    localparam logic [13:0] BIT_C  = 14'(BIT_CYC - 1);
    localparam logic [13:0] HALF_C = 14'(BIT_CYC / 2 - 1);

    logic        rx_s1_reg, rx_s2_reg;
    logic        rx_act_reg, rx_act_next;
    logic [13:0] rx_cnt_reg, rx_cnt_next;
    logic [3:0]  rx_bit_reg, rx_bit_next;
    logic [7:0]  rx_sh_reg, rx_sh_next;
    logic        rx_v_reg, rx_v_next;
    logic        tx_act_reg, tx_act_next;
    logic [13:0] tx_cnt_reg, tx_cnt_next;
    logic [3:0]  tx_bit_reg, tx_bit_next;
    logic [9:0]  tx_sh_reg, tx_sh_next;

    ////////////////////////////////////////////////////////////////////////
    // receiver: sample mid-bit, eight data bits lsb first
    always_comb begin
        rx_act_next = rx_act_reg;
        rx_cnt_next = rx_cnt_reg;
        rx_bit_next = rx_bit_reg;
        rx_sh_next  = rx_sh_reg;
        rx_v_next   = 1'b0;
        if (!rx_act_reg) begin
            if (!rx_s2_reg) begin
                rx_act_next = 1'b1;
                rx_cnt_next = HALF_C;
                rx_bit_next = 4'h0;
            end
        end else if (rx_cnt_reg != 14'h0000) begin
            rx_cnt_next = rx_cnt_reg - 14'h0001;
        end else begin
            rx_cnt_next = BIT_C;
            rx_bit_next = rx_bit_reg + 4'h1;
            if (rx_bit_reg == 4'h0 && rx_s2_reg) begin
                rx_act_next = 1'b0; // glitch, not a start bit
            end else if (rx_bit_reg >= 4'h1 && rx_bit_reg <= 4'h8) begin
                rx_sh_next = {rx_s2_reg, rx_sh_reg[7:1]};
            end else if (rx_bit_reg == 4'h9) begin
                rx_act_next = 1'b0;
                rx_v_next   = rx_s2_reg; // framing error drops byte
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        rx_s1_reg <= i_rxd;
        rx_s2_reg <= rx_s1_reg;
        if (i_srst) begin
            rx_act_reg <= 1'b0;
            rx_cnt_reg <= 14'h0000;
            rx_bit_reg <= 4'h0;
            rx_sh_reg  <= 8'h00;
            rx_v_reg   <= 1'b0;
        end else begin
            rx_act_reg <= rx_act_next;
            rx_cnt_reg <= rx_cnt_next;
            rx_bit_reg <= rx_bit_next;
            rx_sh_reg  <= rx_sh_next;
            rx_v_reg   <= rx_v_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmitter: start, eight data bits, stop
    always_comb begin
        tx_act_next = tx_act_reg;
        tx_cnt_next = tx_cnt_reg;
        tx_bit_next = tx_bit_reg;
        tx_sh_next  = tx_sh_reg;
        if (!tx_act_reg) begin
            if (i_tx_start) begin
                tx_act_next = 1'b1;
                tx_cnt_next = BIT_C;
                tx_bit_next = 4'h0;
                tx_sh_next  = {1'b1, i_tx_data, 1'b0};
            end
        end else if (tx_cnt_reg != 14'h0000) begin
            tx_cnt_next = tx_cnt_reg - 14'h0001;
        end else begin
            tx_cnt_next = BIT_C;
            tx_sh_next  = {1'b1, tx_sh_reg[9:1]};
            tx_bit_next = tx_bit_reg + 4'h1;
            if (tx_bit_reg == 4'h9) begin
                tx_act_next = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            tx_act_reg <= 1'b0;
            tx_cnt_reg <= 14'h0000;
            tx_bit_reg <= 4'h0;
            tx_sh_reg  <= 10'h3FF;
        end else begin
            tx_act_reg <= tx_act_next;
            tx_cnt_reg <= tx_cnt_next;
            tx_bit_reg <= tx_bit_next;
            tx_sh_reg  <= tx_sh_next;
        end
    end

    assign o_txd      = tx_sh_reg[0];
    assign o_tx_busy  = tx_act_reg;
    assign o_rx_data  = rx_sh_reg;
    assign o_rx_valid = rx_v_reg;
endmodule : snvbl_uart

// ---- tb/snvbl_host_model.sv ----
// host side model: sends loader bytes and receives echo frames
`timescale 1ns/100ps
module snvbl_host_model #(
    parameter int unsigned BIT_CYC = snvbl_pkg::BIT_CYC
) (
    // clock
    input  wire logic i_clk_sys,
    // serial pins seen from the host
    input  wire logic i_txd,
    output logic      o_rxd
);
    // line idles high, the level its pull-up would give
    initial o_rxd = 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // one 8N1 frame, lsb first, each bit held one full bit time
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge i_clk_sys);
            o_rxd <= frame[i];
            repeat (BIT_CYC - 1) @(posedge i_clk_sys);
        end
    endtask : send_byte

    ////////////////////////////////////////////////////////////////////////
    // waits a bounded time for a start bit, then samples mid-bit
    task automatic recv_byte(output logic [7:0] b, output logic ok);
        int n;
        n = 0;
        ok = 1'b0;
        b = 8'h00;
        while (i_txd !== 1'b0 && n < 4 * BIT_CYC) begin
            @(posedge i_clk_sys);
            n++;
        end
        if (i_txd === 1'b0) begin
            repeat (BIT_CYC / 2) @(posedge i_clk_sys);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CYC) @(posedge i_clk_sys);
                b[i] = i_txd;
            end
            repeat (BIT_CYC) @(posedge i_clk_sys);
            ok = (i_txd === 1'b1);
        end
    endtask : recv_byte
endmodule : snvbl_host_model

// ---- tb/tb_top.sv ----
// self-checking bench for the serial byte loader
`timescale 1ns/100ps
module tb_top;
    // short steps keep the run length set by the serial link alone
    localparam int unsigned STEP = 20;
    // short bit time too: at 9600 baud one byte costs 130,000 cycles
    localparam int unsigned BIT  = 200;
    typedef struct packed {
        logic [7:0] hi;
        logic [7:0] lo;
        logic [7:0] data;
        logic [7:0] echo;
        logic       prog;
    } snvbl_tb_rec_t;

    logic       clk_sys;
    logic       srst;
    logic       rxd;
    logic       txd;
    logic       sec_bit;
    logic       selftest;
    logic       busy;
    logic       erasing;
    logic       programming;
    logic       locked;
    logic [7:0] last_addr;
    int         err_count;
    int         n_compared;
    // address and data in; expected echo and program step out
    snvbl_tb_rec_t rows [4] = '{
        '{8'h12, 8'h34, 8'hA5, 8'hA5, 1'b1},
        '{8'h00, 8'hFF, 8'hFF, 8'hFF, 1'b0},
        '{8'h80, 8'h00, 8'h5A, 8'h5A, 1'b1},
        '{8'h7F, 8'h01, 8'h00, 8'h00, 1'b1}};

    snvbl_top #(.STEP_CYC(STEP), .BIT_CYC(BIT)) dut (
        .i_clk_sys     (clk_sys),
        .i_srst        (srst),
        .i_rxd         (rxd),
        .o_txd         (txd),
        .i_security_bit(sec_bit),
        .i_selftest    (selftest),
        .o_busy        (busy),
        .o_erasing     (erasing),
        .o_programming (programming),
        .o_locked      (locked),
        .o_last_addr   (last_addr)
    );

    snvbl_host_model #(.BIT_CYC(BIT)) host (
        .i_clk_sys(clk_sys),
        .i_txd    (txd),
        .o_rxd    (rxd)
    );

    ////////////////////////////////////////////////////////////////////////
    // 125 MHz clock
    initial clk_sys = 1'b0;
    always #4 clk_sys = ~clk_sys;

    ////////////////////////////////////////////////////////////////////////
    // compare tasks, one per kind of result
    task automatic check_byte(string nm, logic [7:0] exp, logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : check_byte

    task automatic check_bit(string nm, logic exp, logic got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %b seen %b", nm, exp, got);
        end
    endtask : check_bit

    task automatic check_count(string nm, int exp, int got);
        n_compared++;
        if (got != exp) begin
            err_count++;
            $display("BAD %s expected %0d seen %0d", nm, exp, got);
        end
    endtask : check_count

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report

    // sample one time step after the edge so its updates have landed
    task automatic tick();
        @(posedge clk_sys);
        #1;
    endtask : tick

    // flag levels are sampled by the design in the first cycle after release
    task automatic do_reset(logic sec, logic st);
        @(posedge clk_sys);
        srst     <= 1'b1;
        sec_bit  <= sec;
        selftest <= st;
        repeat (3) tick();
        check_bit("txd_in_reset", 1'b1, txd);
        check_bit("busy_in_reset", 1'b0, busy);
        @(posedge clk_sys);
        srst <= 1'b0;
        repeat (3) tick();
    endtask : do_reset

    ////////////////////////////////////////////////////////////////////////
    // one record: the data byte is still in its stop bit while the device
    // erases, programs and starts the echo, so sending and watching run in parallel
    task automatic do_record(snvbl_tb_rec_t r);
        int n;
        int e;
        int p;
        logic order_bad;
        logic [7:0] echo;
        logic ok;
        n = 0;
        e = 0;
        p = 0;
        order_bad = 1'b0;
        host.send_byte(r.hi);
        host.send_byte(r.lo);
        fork
            host.send_byte(r.data);
            begin
                // the data frame runs some ten bit times before it is taken
                while (erasing !== 1'b1 && n < 12 * BIT) begin
                    tick();
                    n++;
                end
                while (busy === 1'b1 && n < 14 * BIT) begin
                    if (erasing === 1'b1) e++;
                    if (programming === 1'b1) p++;
                    if (erasing === 1'b1 && p > 0) order_bad = 1'b1;
                    tick();
                    n++;
                end
                host.recv_byte(echo, ok);
            end
        join
        check_count("erase_cycles", STEP, e);
        check_count("prog_cycles", r.prog ? STEP : 0, p);
        check_bit("erase_before_prog", 1'b0, order_bad);
        check_bit("echo_framed", 1'b1, ok);
        check_byte("echo", r.echo, echo);
        check_byte("last_addr", r.lo, last_addr);
    endtask : do_record

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        err_count  = 0;
        n_compared = 0;
        srst       = 1'b1;
        sec_bit    = 1'b0;
        selftest   = 1'b0;
        repeat (3) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (3) tick();
        check_bit("locked_unsecured", 1'b0, locked);
        check_bit("txd_idle", 1'b1, txd);
        // leading null must be thrown away or every record misaligns
        host.send_byte(8'h00);
        foreach (rows[i]) do_record(rows[i]);
        // secured session done after the records, so the wipe below restores loading
        do_reset(1'b1, 1'b0);
        check_bit("locked_secured", 1'b1, locked);
        check_bit("locked_idle", 1'b0, busy);
        do_reset(1'b1, 1'b1);
        check_bit("wipe_running", 1'b1, busy);
        check_bit("wipe_unlocked", 1'b0, locked);
        for (int n = 0; n < 256 * 4 * STEP + 1000 && busy === 1'b1; n++)
            tick();
        check_bit("wipe_done", 1'b0, busy);
        host.send_byte(8'h00);
        do_record('{8'h00, 8'hC3, 8'h3C, 8'h3C, 1'b1});
        final_report();
    end

    // watchdog: the run needs about 45,000 cycles
    initial begin
        repeat (90_000) @(posedge clk_sys);
        err_count++;
        final_report();
    end
endmodule : tb_top
